/* src/dfc_pkg.sv */
// Shared constants and types for the digital filter and change/generation block
package dfc_pkg;
	//--------------------------------------------------------------
	// Sizes
	//--------------------------------------------------------------
	localparam int NUM_MOD    = 2;
	localparam int MOD_LINES  = 8;
	localparam int NUM_LINES  = 16;
	localparam int WORD_W     = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int LVL_W      = 5;
	localparam logic [LVL_W-1:0] LVL_FULL = 5'h10;
	localparam logic [LVL_W-1:0] LVL_HIGH = 5'h08;
	localparam logic [LVL_W-1:0] CD_BLOCK = 5'h04;
	//--------------------------------------------------------------
	// Timing
	//--------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 10000;
	localparam int PASS_STEP_PS  = 25000;
	localparam logic [1:0] FILT_N = 2'h2;
	localparam logic [23:0] ACC_STEP = 24'(CLK_PERIOD_PS);
	//--------------------------------------------------------------
	// Generator states and modes
	//--------------------------------------------------------------
	typedef enum logic [3:0] {
		GEN_IDLE = 4'h1,
		GEN_LOAD = 4'h2,
		GEN_RUN  = 4'h4,
		GEN_DONE = 4'h8
	} dfc_gen_st_t;
	typedef enum logic [1:0] {
		MODE_FINITE   = 2'h0,
		MODE_REGEN    = 2'h1,
		MODE_ONBOARD  = 2'h2,
		MODE_NONREGEN = 2'h3
	} dfc_mode_t;

	// Filter clock period in ps: the pass width split over FILT_N samples
	function automatic logic [23:0] filt_period(input logic [7:0] width);
		filt_period = 24'(int'(width) * PASS_STEP_PS / int'(FILT_N));
	endfunction : filt_period
endpackage : dfc_pkg

/* src/dfc_fifo_if.sv */
// Handshake bundle between the block and its sample FIFO
`timescale 1ns/100ps
interface dfc_fifo_if #(parameter int W = 16, parameter int LW = 5);
	logic          push_valid;
	logic          push_ready;
	logic [W-1:0]  push_data;
	logic          pop_valid;
	logic          pop_ready;
	logic [W-1:0]  pop_data;
	logic [LW-1:0] level;
	logic          flush;
	modport user  (output push_valid, push_data, pop_ready, flush,
		input push_ready, pop_valid, pop_data, level);
	modport store (input push_valid, push_data, pop_ready, flush,
		output push_ready, pop_valid, pop_data, level);
endinterface : dfc_fifo_if

/* src/dfc_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module dfc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic   ref_clk_in,
	input wire logic   rst_in,
	dfc_fifo_if.store  q
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      lvl_ff;
	wire              do_push;
	wire              do_pop;

	// Handshakes; full and empty come straight from the level
	assign q.push_ready = (lvl_ff != (AW+1)'(DEPTH));
	assign q.pop_valid  = (lvl_ff != '0);
	assign q.pop_data   = mem[rd_ff];
	assign q.level      = lvl_ff;
	assign do_push      = q.push_valid & q.push_ready;
	assign do_pop       = q.pop_valid & q.pop_ready;

	// Storage has no reset, it is only read below the level
	always_ff @(posedge ref_clk_in)
	begin
		if (do_push)
			mem[wr_ff] <= q.push_data;
	end

	// Pointers wrap naturally, depth is a power of two
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			lvl_ff <= '0;
		end
		else if (q.flush)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			lvl_ff <= '0;
		end
		else
		begin
			wr_ff  <= wr_ff + AW'(do_push);
			rd_ff  <= rd_ff + AW'(do_pop);
			lvl_ff <= lvl_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : dfc_fifo

/* src/dfc_top.sv */
// Input debounce, change detection and buffered output generation
// Functional notes
// - Filter works only for hardware-timed input on parallel modules.
// - One filter setting shared by all lines of a module.
// - Filter samples inputs on a filter clock from the timebase.
// - Pass width set in 25 ns steps; filter clock derived from it.
// - Pulses under half the pass width never get through.
// - Change propagates after consecutive filter samples at new level.
// - Configured edge on any detect line raises the change event.
// - Change event can drive any programmable function terminal.
// - Each line rising or falling; any hit samples all task lines.
// - Detect lines need not be part of the sampled set.
// - Buffered samples go via FIFO in blocks; else straight out.
// - Software-timed output: one host command writes one value.
// - Hardware-timed output paced by internal or external clock.
// - Hardware-timed output always runs through the FIFO.
// - Serial module in hardware task refuses software writes.
// - Hardware task may not mix parallel and serial modules.
// - Host data enters the FIFO before reaching the modules.
// - Finite mode stops after the programmed sample count.
// - Regeneration: host streams buffer continuously, stall just holds.
// - Onboard regeneration replays FIFO content; no host writes after load.
// - Non-regeneration never repeats; empty FIFO is an error.
// - Parallel module in upper slots shrinks usable FIFO depth.
`timescale 1ns/100ps
module dfc_top (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic [15:0] din_pin_in,
	input  wire logic [1:0]  mod_parallel_in,
	input  wire logic [1:0]  filt_en_in,
	input  wire logic [15:0] min_pass_width_in,
	input  wire logic        di_hw_timed_in,
	input  wire logic [15:0] rise_en_in,
	input  wire logic [15:0] fall_en_in,
	input  wire logic [15:0] task_mask_in,
	input  wire logic        cd_run_in,
	input  wire logic        cd_buffered_in,
	input  wire logic [3:0]  pft_route_cd_in,
	input  wire logic        cd_ready_in,
	output logic      [15:0] din_filt_out,
	output logic             edge_change_event_out,
	output logic      [3:0]  programmable_function_terminal_out,
	output logic      [15:0] cd_data_out,
	output logic             cd_valid_out,
	output logic             cd_overflow_out,
	input  wire logic        do_start_in,
	input  wire logic        do_stop_in,
	input  wire logic [1:0]  do_mode_in,
	input  wire logic [15:0] do_nsamp_in,
	input  wire logic        do_ext_src_in,
	input  wire logic        do_ext_clk_in,
	input  wire logic [15:0] do_rate_div_in,
	input  wire logic [1:0]  do_hw_mods_in,
	input  wire logic [1:0]  do_serial_in,
	input  wire logic        do_high_slot_in,
	input  wire logic        load_done_in,
	input  wire logic [15:0] host_wdata_in,
	input  wire logic        host_wvalid_in,
	output logic             host_wready_out,
	input  wire logic [1:0]  sw_mods_in,
	input  wire logic        sw_write_in,
	input  wire logic [15:0] sw_data_in,
	input  wire logic        err_clr_in,
	output logic      [15:0] do_data_out,
	output logic             do_update_out,
	output logic             do_busy_out,
	output logic             sw_refused_out,
	output logic             cfg_err_out,
	output logic             underflow_out
);
	//--------------------------------------------------------------
	// Input synchroniser and filter
	//--------------------------------------------------------------
	logic [15:0] s1_ff, s2_ff, s3_ff, pin_ff, filt_ff, prev_ff;
	logic [1:0]  cnt_ff [16];
	logic [23:0] acc_ff [2];
	logic [1:0]  fclk_en, filt_act;

	// Three stages; a level is taken once stages two and three agree
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			pin_ff <= '0;
		end
		else
		begin
			s1_ff  <= din_pin_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			pin_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));
		end
	end

	// One filter clock per module, fractional so 25 ns steps stay exact
	for (genvar m = 0; m < dfc_pkg::NUM_MOD; m++)
	begin : g_mod
		wire [7:0]  w_set = min_pass_width_in[8*m +: 8];
		wire [23:0] per   = dfc_pkg::filt_period((w_set == 8'h00) ? 8'h01 : w_set);
		assign filt_act[m] = filt_en_in[m] & di_hw_timed_in & mod_parallel_in[m];
		assign fclk_en[m]  = (acc_ff[m] + dfc_pkg::ACC_STEP) >= per;
		always_ff @(posedge ref_clk_in or posedge rst_in)
		begin
			if (rst_in)
				acc_ff[m] <= '0;
			else if (!filt_act[m])
				acc_ff[m] <= '0;
			else if (fclk_en[m])
				acc_ff[m] <= acc_ff[m] + dfc_pkg::ACC_STEP - per;
			else
				acc_ff[m] <= acc_ff[m] + dfc_pkg::ACC_STEP;
		end
	end

	// Per line: FILT_N agreeing samples at Tp/FILT_N reject below Tp/2
	for (genvar l = 0; l < dfc_pkg::NUM_LINES; l++)
	begin : g_line
		localparam int M = l / dfc_pkg::MOD_LINES;
		wire diff = pin_ff[l] ^ filt_ff[l];
		wire hit  = (cnt_ff[l] + 2'h1) == dfc_pkg::FILT_N;
		always_ff @(posedge ref_clk_in or posedge rst_in)
		begin
			if (rst_in)
			begin
				cnt_ff[l]  <= '0;
				filt_ff[l] <= 1'b0;
			end
			else if (!filt_act[M])
			begin
				cnt_ff[l]  <= '0;
				filt_ff[l] <= pin_ff[l];
			end
			else if (fclk_en[M])
			begin
				cnt_ff[l]  <= (diff && !hit) ? cnt_ff[l] + 2'h1 : 2'h0;
				filt_ff[l] <= filt_ff[l] ^ (diff & hit);
			end
		end
	end
	assign din_filt_out = filt_ff;

	//--------------------------------------------------------------
	// Change detection
	//--------------------------------------------------------------
	dfc_fifo_if #(.W(16), .LW(dfc_pkg::LVL_W)) cdq ();
	logic        evt_ff, dvld_ff, ovf_ff, blk_ff;
	logic [3:0]  pft_ff;
	logic [15:0] dir_ff;
	wire  [15:0] edges = (filt_ff & ~prev_ff & rise_en_in) | (~filt_ff & prev_ff & fall_en_in);
	wire         cd_hit = cd_run_in & (|edges);
	wire  [15:0] sample = filt_ff & task_mask_in;
	wire         cd_open = blk_ff | ~cd_run_in;
	wire         ovf_set = cd_hit & (cd_buffered_in ? ~cdq.push_ready : dvld_ff & ~cd_ready_in);

	assign cdq.push_valid = cd_hit & cd_buffered_in;
	assign cdq.push_data  = sample;
	assign cdq.pop_ready  = cd_buffered_in & cd_open & cd_ready_in;
	assign cdq.flush      = 1'b0;
	assign cd_valid_out   = cd_buffered_in ? cdq.pop_valid & cd_open : dvld_ff;
	assign cd_data_out    = cd_buffered_in ? cdq.pop_data : dir_ff;
	assign edge_change_event_out              = evt_ff;
	assign programmable_function_terminal_out = pft_ff;
	assign cd_overflow_out                    = ovf_ff;

	dfc_fifo #(.WIDTH(16), .DEPTH(dfc_pkg::FIFO_DEPTH)) u_cd_fifo (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.q          (cdq)
	);

	// Event, routing, direct sample; blocks open at CD_BLOCK words
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prev_ff <= '0;
			evt_ff  <= 1'b0;
			pft_ff  <= '0;
			dir_ff  <= '0;
			dvld_ff <= 1'b0;
			blk_ff  <= 1'b0;
			ovf_ff  <= 1'b0;
		end
		else
		begin
			prev_ff <= filt_ff;
			evt_ff  <= cd_hit;
			pft_ff  <= {4{cd_hit}} & pft_route_cd_in;
			if (cd_hit && !cd_buffered_in)
				dir_ff <= sample;
			dvld_ff <= (cd_hit & ~cd_buffered_in) | (dvld_ff & ~cd_ready_in);
			blk_ff  <= (cdq.level >= dfc_pkg::CD_BLOCK) | (blk_ff & (cdq.level != '0));
			ovf_ff  <= ovf_set | (ovf_ff & ~err_clr_in);
		end
	end

	//--------------------------------------------------------------
	// Output generation
	//--------------------------------------------------------------
	dfc_fifo_if #(.W(16), .LW(dfc_pkg::LVL_W)) doq ();
	dfc_pkg::dfc_gen_st_t st_ff, nxt_st;
	logic        e1_ff, e2_ff, e3_ff, elvl_ff, rc_vld_ff, upd_ff, ref_ff, cfg_ff, unf_ff;
	logic [15:0] div_ff, smp_ff, do_ff, rc_ff;
	wire         st_run   = (st_ff == dfc_pkg::GEN_RUN);
	wire         onboard  = (do_mode_in == dfc_pkg::MODE_ONBOARD);
	wire         mix      = (|(do_hw_mods_in & do_serial_in)) & (|(do_hw_mods_in & ~do_serial_in));
	wire         ext_rise = e2_ff & e3_ff & ~elvl_ff;
	wire         div_hit  = (div_ff + 16'h1) >= do_rate_div_in;
	wire         tick     = st_run & (do_ext_src_in ? ext_rise : div_hit);
	wire         fire     = tick & doq.pop_valid;
	wire         starve   = tick & ~doq.pop_valid;
	wire         unf_set  = starve & (do_mode_in == dfc_pkg::MODE_NONREGEN);
	wire         fin_hit  = fire & (do_mode_in == dfc_pkg::MODE_FINITE)
		& ((smp_ff + 16'h1) == do_nsamp_in);
	wire [4:0]   lim      = do_high_slot_in ? dfc_pkg::LVL_HIGH : dfc_pkg::LVL_FULL;
	wire         host_ok  = ~rc_vld_ff & (doq.level < lim) & ~(st_run & onboard)
		& (st_ff != dfc_pkg::GEN_DONE);
	wire         sw_bad   = sw_write_in & (|(sw_mods_in & do_serial_in & do_hw_mods_in));
	wire         sw_ok    = sw_write_in & ~sw_bad;
	logic [15:0] nxt_do;

	assign doq.push_valid = rc_vld_ff | (host_wvalid_in & host_ok);
	assign doq.push_data  = rc_vld_ff ? rc_ff : host_wdata_in;
	assign doq.pop_ready  = tick;
	assign doq.flush      = do_stop_in;
	assign host_wready_out = host_ok & doq.push_ready;

	dfc_fifo #(.WIDTH(16), .DEPTH(dfc_pkg::FIFO_DEPTH)) u_do_fifo (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.q          (doq)
	);

	// Lane merge: hardware lanes take FIFO words on a fire, otherwise written lanes take host writes
	for (genvar m = 0; m < dfc_pkg::NUM_MOD; m++)
	begin : g_lane
		assign nxt_do[8*m +: 8] = (fire && do_hw_mods_in[m]) ? doq.pop_data[8*m +: 8] :
			(sw_ok && sw_mods_in[m]) ? sw_data_in[8*m +: 8] : do_ff[8*m +: 8];
	end

	// Sequencer; a mixed module set never leaves idle
	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			dfc_pkg::GEN_IDLE:
				if (do_start_in && !mix)
					nxt_st = onboard ? dfc_pkg::GEN_LOAD : dfc_pkg::GEN_RUN;
			dfc_pkg::GEN_LOAD:
				if (do_stop_in)
					nxt_st = dfc_pkg::GEN_IDLE;
				else if (load_done_in)
					nxt_st = dfc_pkg::GEN_RUN;
			dfc_pkg::GEN_RUN:
				if (do_stop_in)
					nxt_st = dfc_pkg::GEN_IDLE;
				else if (fin_hit || unf_set)
					nxt_st = dfc_pkg::GEN_DONE;
			dfc_pkg::GEN_DONE:
				if (do_stop_in)
					nxt_st = dfc_pkg::GEN_IDLE;
			default:
				nxt_st = dfc_pkg::GEN_IDLE;
		endcase
	end

	// External pace pin: three stages, edge once stages two and three agree
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			e1_ff   <= 1'b0;
			e2_ff   <= 1'b0;
			e3_ff   <= 1'b0;
			elvl_ff <= 1'b0;
		end
		else
		begin
			e1_ff   <= do_ext_clk_in;
			e2_ff   <= e1_ff;
			e3_ff   <= e2_ff;
			elvl_ff <= (e2_ff == e3_ff) ? e2_ff : elvl_ff;
		end
	end

	// Pace divider, counters, recirculation and flags; set beats clear
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_ff     <= dfc_pkg::GEN_IDLE;
			div_ff    <= '0;
			smp_ff    <= '0;
			do_ff     <= '0;
			rc_ff     <= '0;
			rc_vld_ff <= 1'b0;
			upd_ff    <= 1'b0;
			ref_ff    <= 1'b0;
			cfg_ff    <= 1'b0;
			unf_ff    <= 1'b0;
		end
		else
		begin
			st_ff     <= nxt_st;
			div_ff    <= (!st_run || div_hit) ? 16'h0 : div_ff + 16'h1;
			smp_ff    <= st_run ? smp_ff + 16'(fire) : 16'h0;
			do_ff     <= nxt_do;
			rc_ff     <= doq.pop_data;
			rc_vld_ff <= fire & onboard;
			upd_ff    <= fire | sw_ok;
			ref_ff    <= sw_bad;
			cfg_ff    <= (do_start_in & mix) | (cfg_ff & ~err_clr_in);
			unf_ff    <= unf_set | (unf_ff & ~err_clr_in);
		end
	end
	assign do_data_out    = do_ff;
	assign do_update_out  = upd_ff;
	assign do_busy_out    = (st_ff != dfc_pkg::GEN_IDLE);
	assign sw_refused_out = ref_ff;
	assign cfg_err_out    = cfg_ff;
	assign underflow_out  = unf_ff;

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_hit;
		cd_hit && !cd_buffered_in;
	endsequence
	sequence s_report;
		cd_valid_out && edge_change_event_out;
	endsequence
	property p_bypass;
		!filt_act[0] |=> din_filt_out[7:0] == $past(pin_ff[7:0]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("filter bypass wrong");
	property p_hold;
		filt_act[0] && !fclk_en[0] |=> $stable(din_filt_out[7:0]);
	endproperty
	a_hold: assert property (p_hold) else $error("filter moved off clock");
	property p_direct;
		s_hit |=> s_report ##0 cd_data_out == $past(sample);
	endproperty
	a_direct: assert property (p_direct) else $error("direct sample lost");
	property p_route;
		cd_hit |=> programmable_function_terminal_out == $past(pft_route_cd_in);
	endproperty
	a_route: assert property (p_route) else $error("terminal route wrong");
	property p_refuse;
		sw_bad && !fire |=> sw_refused_out && $stable(do_data_out);
	endproperty
	a_refuse: assert property (p_refuse) else $error("serial write not refused");
	property p_mix;
		st_ff == dfc_pkg::GEN_IDLE && do_start_in && mix |=> !do_busy_out && cfg_err_out;
	endproperty
	a_mix: assert property (p_mix) else $error("mixed task started");
	property p_unf;
		unf_set && !do_stop_in |=> underflow_out && st_ff == dfc_pkg::GEN_DONE
			##1 $stable(do_data_out[15:0]) || $past(sw_ok);
	endproperty
	a_unf: assert property (p_unf) else $error("underflow not handled");
	property p_finite;
		fin_hit && !do_stop_in |=> st_ff == dfc_pkg::GEN_DONE ##1 !do_update_out[*2];
	endproperty
	a_finite: assert property (p_finite) else $error("finite run overran");
	property p_onboard;
		st_run && onboard |-> !host_wready_out;
	endproperty
	a_onboard: assert property (p_onboard) else $error("host write during replay");
endmodule : dfc_top

/* bench/dfc_host_model.sv */
// Host-side model: streams output words and accepts change samples
`timescale 1ns/100ps
module dfc_host_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        feed_go_in,
	input  wire logic [4:0]  feed_n_in,
	input  wire logic [15:0] feed_base_in,
	input  wire logic        wready_in,
	output logic      [15:0] wdata_out,
	output logic             wvalid_out,
	input  wire logic        slow_in,
	input  wire logic        cd_valid_in,
	input  wire logic [15:0] cd_data_in,
	output logic             cd_ready_out,
	output logic      [15:0] cd_word_out,
	output logic      [7:0]  cd_cnt_out
);
	logic [4:0] left_ff;
	logic       stall_ff;
	// Slow mode takes a sample only every other cycle
	assign cd_ready_out = !slow_in || stall_ff;
	// Word held until taken; idle data toggles so it never looks stable
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			left_ff     <= 5'h00;
			wvalid_out  <= 1'b0;
			wdata_out   <= 16'h0000;
			stall_ff    <= 1'b0;
			cd_cnt_out  <= 8'h00;
			cd_word_out <= 16'h0000;
		end
		else
		begin
			stall_ff <= !stall_ff;
			if (feed_go_in)
			begin
				left_ff    <= feed_n_in;
				wvalid_out <= (feed_n_in != 5'h00);
				wdata_out  <= feed_base_in;
			end
			else if (wvalid_out && wready_in)
			begin
				left_ff    <= left_ff - 5'h01;
				wvalid_out <= (left_ff > 5'h01);
				wdata_out  <= wdata_out + 16'h0001;
			end
			else if (!wvalid_out)
				wdata_out <= ~wdata_out;
			if (cd_valid_in && cd_ready_out)
			begin
				cd_cnt_out  <= cd_cnt_out + 8'h01;
				cd_word_out <= cd_data_in;
			end
		end
	end
endmodule : dfc_host_model

/* bench/tb_dfc_top.sv */
// Self-checking bench for the filter, change-detect and output block
`timescale 1ns/100ps
module tb_dfc_top;
	typedef struct packed {logic [1:0] fe; logic [15:0] pin; logic [15:0] exp;} dfc_row_t;
	logic        clk, rst, di_hw, cd_run, cd_buf, cd_rdy, start, stop, ext_src, ext_clk;
	logic        high_slot, load_done, wvalid, wready, sw_write, err_clr, feed_go, slow;
	logic        ev, cd_valid, cd_ovf, upd, busy, refused, cfg_err, uflow, seen;
	logic [1:0]  mod_par, filt_en, mode, hw_mods, serial, sw_mods;
	logic [3:0]  route, pft;
	logic [4:0]  feed_n;
	logic [7:0]  cd_cnt, c0;
	logic [15:0] din, width, rise, fall, mask, nsamp, div, wdata, sw_data, base;
	logic [15:0] cd_word, filt, cd_data, do_data;
	logic [15:0] exp_q[$];
	int          err_count, total_checks;
	dfc_row_t    rows[4] = '{'{2'h0, 16'ha5c3, 16'ha5c3}, '{2'h3, 16'hffff, 16'hffff},
		'{2'h1, 16'h0f0f, 16'h0f0f}, '{2'h0, 16'h0000, 16'h0000}};

	dfc_top dut (.ref_clk_in(clk), .rst_in(rst), .din_pin_in(din), .mod_parallel_in(mod_par),
		.filt_en_in(filt_en), .min_pass_width_in(width), .di_hw_timed_in(di_hw),
		.rise_en_in(rise), .fall_en_in(fall), .task_mask_in(mask), .cd_run_in(cd_run),
		.cd_buffered_in(cd_buf), .pft_route_cd_in(route), .cd_ready_in(cd_rdy),
		.din_filt_out(filt), .edge_change_event_out(ev),
		.programmable_function_terminal_out(pft), .cd_data_out(cd_data),
		.cd_valid_out(cd_valid), .cd_overflow_out(cd_ovf), .do_start_in(start),
		.do_stop_in(stop), .do_mode_in(mode), .do_nsamp_in(nsamp), .do_ext_src_in(ext_src),
		.do_ext_clk_in(ext_clk), .do_rate_div_in(div), .do_hw_mods_in(hw_mods),
		.do_serial_in(serial), .do_high_slot_in(high_slot), .load_done_in(load_done),
		.host_wdata_in(wdata), .host_wvalid_in(wvalid), .host_wready_out(wready),
		.sw_mods_in(sw_mods), .sw_write_in(sw_write), .sw_data_in(sw_data),
		.err_clr_in(err_clr), .do_data_out(do_data), .do_update_out(upd),
		.do_busy_out(busy), .sw_refused_out(refused), .cfg_err_out(cfg_err),
		.underflow_out(uflow));

	dfc_host_model host (.clk_in(clk), .rst_in(rst), .feed_go_in(feed_go), .feed_n_in(feed_n),
		.feed_base_in(base), .wready_in(wready), .wdata_out(wdata), .wvalid_out(wvalid),
		.slow_in(slow), .cd_valid_in(cd_valid), .cd_data_in(cd_data), .cd_ready_out(cd_rdy),
		.cd_word_out(cd_word), .cd_cnt_out(cd_cnt));

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic go;
		start = 1'b1;
		tick(1);
		start = 1'b0;
	endtask : go
	task automatic halt;
		stop = 1'b1;
		tick(1);
		stop = 1'b0;
		tick(1);
	endtask : halt
	// Pulse of len cycles on the given lines; reports whether it got through
	task automatic pulse(input logic [15:0] bits, input int len, output logic hit);
		hit = 1'b0;
		din = bits;
		for (int i = 0; i < 40; i++)
		begin
			if (i == len)
				din = 16'h0000;
			tick(1);
			hit = hit | (|(filt & bits));
		end
	endtask : pulse
	task automatic cd_hit(input logic [15:0] pin, input logic [15:0] exp);
		int k;
		c0 = cd_cnt;
		din = pin;
		for (k = 0; k < 12 && ev !== 1'b1; k++)
			tick(1);
		chk(16'(k < 12), 16'h1);
		chk(16'(pft), 16'h5);
		tick(1);
		chk(16'(ev), 16'h0);
		tick(3);
		chk(cd_word, exp);
		chk(16'(cd_cnt - c0), 16'h1);
	endtask : cd_hit
	// Bounded wait while the host still has words to hand over
	task automatic feed(input logic [4:0] n, input logic [15:0] b);
		int k;
		feed_n = n;
		base = b;
		feed_go = 1'b1;
		tick(1);
		feed_go = 1'b0;
		for (k = 0; k < 40 && wvalid === 1'b1; k++)
			tick(1);
		chk(16'(k < 40 || high_slot), 16'h1);
	endtask : feed
	// Every output update must carry the next expected word
	always @(negedge clk)
		if (upd === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(16'h1, 16'h0);
			else
				chk(do_data, exp_q.pop_front());
		end
	// Hang guard
	initial
	begin
		#900000;
		err_count++;
		conclude();
	end

	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial
	begin
		{di_hw, cd_run, cd_buf, start, stop, ext_src, ext_clk, high_slot, load_done} = '0;
		{sw_write, err_clr, feed_go, slow, filt_en, mode, hw_mods, serial, sw_mods} = '0;
		{route, feed_n, din, width, rise, fall, mask, nsamp, div, sw_data, base} = '0;
		mod_par = 2'h3;
		rst = 1'b1;
		tick(16);
		rst = 1'b0;
		tick(1);
		chk(16'(busy), 16'h0);
		chk(16'(wready), 16'h1);
		chk(16'({cd_valid, uflow, cfg_err, ev, cd_ovf, refused}), 16'h0);
		// Filter enable ignored without a hardware-timed input task
		foreach (rows[i])
		begin
			filt_en = rows[i].fe;
			din = rows[i].pin;
			tick(6);
			chk(filt, rows[i].exp);
		end
		// Module 0 filtered: 100 ns pass width, module 1 left raw
		width = 16'h0004;
		mod_par = 2'h1;
		filt_en = 2'h1;
		di_hw = 1'b1;
		pulse(16'h0001, 2, seen);
		chk(16'(seen), 16'h0);
		pulse(16'h0080, 2, seen);
		chk(16'(seen), 16'h0);
		pulse(16'h0100, 2, seen);
		chk(16'(seen), 16'h1);
		pulse(16'h0001, 20, seen);
		chk(16'(seen), 16'h1);
		di_hw = 1'b0;
		pulse(16'h0001, 2, seen);
		chk(16'(seen), 16'h1);
		// Line 8 rising, line 0 falling; the task samples only 7:0
		filt_en = 2'h0;
		mod_par = 2'h3;
		rise = 16'h0100;
		fall = 16'h0001;
		mask = 16'h00ff;
		route = 4'h5;
		cd_run = 1'b1;
		cd_hit(16'h01ab, 16'h00ab);
		cd_hit(16'h01aa, 16'h00aa);
		c0 = cd_cnt;
		din = 16'h01ae;
		tick(10);
		chk(16'(cd_cnt - c0), 16'h0);
		// Buffered: nothing offered until a block of four waits
		cd_buf = 1'b1;
		slow = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			din = 16'h00ae;
			tick(8);
			din = 16'h01ae;
			tick(8);
			if (i == 2)
				chk(16'(cd_valid), 16'h0);
		end
		tick(20);
		chk(16'(cd_cnt - c0), 16'h4);
		chk(cd_word, 16'h00ae);
		{cd_run, cd_buf, slow} = '0;
		// Finite run of three words paced by the divider
		hw_mods = 2'h3;
		div = 16'h0002;
		nsamp = 16'h0003;
		feed(5'h03, 16'h1230);
		exp_q = '{16'h1230, 16'h1231, 16'h1232};
		go();
		tick(30);
		chk(16'(exp_q.size()), 16'h0);
		chk(16'(busy), 16'h1);
		halt();
		chk(16'(busy), 16'h0);
		// Onboard replay of two words on the external pace pin; host stays silent
		mode = 2'h2;
		ext_src = 1'b1;
		feed(5'h02, 16'h0a01);
		go();
		load_done = 1'b1;
		tick(1);
		load_done = 1'b0;
		tick(2);
		chk(16'(wready), 16'h0);
		exp_q = '{16'h0a01, 16'h0a02, 16'h0a01, 16'h0a02, 16'h0a01};
		repeat (5)
		begin
			ext_clk = 1'b1;
			tick(4);
			ext_clk = 1'b0;
			tick(4);
		end
		chk(16'(exp_q.size()), 16'h0);
		halt();
		ext_src = 1'b0;
		// Non-regeneration starved after one word
		mode = 2'h3;
		div = 16'h0004;
		feed(5'h01, 16'h5501);
		exp_q = '{16'h5501};
		go();
		tick(20);
		chk(16'(uflow), 16'h1);
		chk(do_data, 16'h5501);
		err_clr = 1'b1;
		tick(1);
		err_clr = 1'b0;
		tick(1);
		chk(16'(uflow), 16'h0);
		halt();
		// Mixed parallel and serial hardware task is turned away
		serial = 2'h1;
		go();
		tick(2);
		chk(16'(cfg_err), 16'h1);
		chk(16'(busy), 16'h0);
		// Software writes: serial lane owned by hardware refused, parallel lane taken
		hw_mods = 2'h1;
		sw_mods = 2'h1;
		sw_data = 16'h00ff;
		sw_write = 1'b1;
		tick(1);
		sw_write = 1'b0;
		chk(16'(refused), 16'h1);
		exp_q = '{16'hbe01};
		sw_mods = 2'h2;
		sw_data = 16'hbe00;
		sw_write = 1'b1;
		tick(1);
		sw_write = 1'b0;
		tick(2);
		chk(16'(exp_q.size()), 16'h0);
		// Regeneration: a starved tick only stalls, words fed mid-run still go out
		mode = 2'h1;
		serial = 2'h0;
		hw_mods = 2'h3;
		go();
		tick(12);
		chk(16'(uflow), 16'h0);
		chk(16'(busy), 16'h1);
		chk(16'(wready), 16'h1);
		exp_q = '{16'h7700, 16'h7701};
		feed(5'h02, 16'h7700);
		tick(12);
		chk(16'(exp_q.size()), 16'h0);
		halt();
		// Upper-slot module limits the FIFO to eight, then full depth is filled and drained
		{mode, serial} = '0;
		hw_mods = 2'h3;
		high_slot = 1'b1;
		feed(5'h0a, 16'h2000);
		chk(16'(wready), 16'h0);
		chk(16'(wvalid), 16'h1);
		halt();
		tick(10);
		halt();
		high_slot = 1'b0;
		feed(5'h10, 16'h3000);
		tick(4);
		chk(16'({wready, wvalid}), 16'h0);
		nsamp = 16'h0010;
		div = 16'h0001;
		for (int i = 0; i < 16; i++)
			exp_q.push_back(16'h3000 + 16'(i));
		go();
		tick(40);
		chk(16'(exp_q.size()), 16'h0);
		halt();
		conclude();
	end
endmodule : tb_dfc_top
